// File: pkg/timer_pair_consts.svh
// Constants for the dual timer/counter with external interrupt detection.
// Assumes a byte-wide register port addressed at the printed offsets.
//
// Functional notes
// - Mode field picks 13, 16, 8-reload, split
// - Timer one mode 11 stops and holds
// - 13-bit mode uses five low bits
// - Low byte reloads from high on overflow
// - Timer mode counts cycles, wraps, sets flag
// - Count only while run bit set
// - Gate set needs pin high too
// - Select bit picks falling edges or cycles
// - Input sampled per cycle, high then low
// - Overflow flag cleared on interrupt vector
// - Type bit picks low level or falling edge
// - Edge flag cleared automatically on service
// - Mode register bit layout per timer
// - Control register bit layout
// - Timer one overflow is a rate source
// - Split mode: high byte uses timer one controls
// - Machine cycle is clock over twelve
`ifndef TIMER_PAIR_CONSTS_SVH
`define TIMER_PAIR_CONSTS_SVH

// Register offsets.
`define TPC_CTL_ADDR 8'h88
`define TPC_MODE_ADDR 8'h89
`define TPC_CNT_LO0_ADDR 8'h8A
`define TPC_CNT_LO1_ADDR 8'h8B
`define TPC_CNT_HI0_ADDR 8'h8C
`define TPC_CNT_HI1_ADDR 8'h8D

// Control register bit positions.
`define TPC_OVF1_BIT 7
`define TPC_RUN1_BIT 6
`define TPC_OVF0_BIT 5
`define TPC_RUN0_BIT 4
`define TPC_IRQF1_BIT 3
`define TPC_KIND1_BIT 2
`define TPC_IRQF0_BIT 1
`define TPC_KIND0_BIT 0

// Mode register field positions within each nibble.
`define TPC_GATE_BIT 3
`define TPC_SEL_BIT 2
`define TPC_MODE_HI 1
`define TPC_MODE_LO 0

// Reset values.
`define TPC_CTL_RST 8'h00
`define TPC_MODE_RST 8'h00
`define TPC_CNT_RST 8'h00

// Machine cycle pacing in core clocks.
`define TPC_CYCLE_DIV 12

`endif

// File: pkg/timer_pair_pkg.sv
// Types for the dual timer/counter block.
// Assumes the constants header is included by the design file.
package timer_pair_pkg;

	// Operating modes of one timer.
	typedef enum logic [1:0] {
		MODE_13BIT = 2'b00,
		MODE_16BIT = 2'b01,
		MODE_RELOAD8 = 2'b10,
		MODE_SPLIT = 2'b11
	} timer_mode_t;

endpackage

// File: design/timer_pair.sv
// Dual timer/counter with external interrupt flag detection.
// Assumes synchronous pin inputs and a one-cycle read latency bus master.
`include "timer_pair_consts.svh"
`timescale 1ns/1ns

module timer_pair #(
	parameter int DIV = `TPC_CYCLE_DIV
)
(
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// Register port.
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// External pins.
	input wire logic i_count_input_zero,
	input wire logic i_count_input_one,
	input wire logic i_ext_irq_pin_zero,
	input wire logic i_ext_irq_pin_one,
	// Interrupt service acknowledges from the processor.
	input wire logic i_ack_ovf_zero,
	input wire logic i_ack_ovf_one,
	input wire logic i_ack_irq_zero,
	input wire logic i_ack_irq_one,
	// Rate source and flag copies.
	output logic o_rate_one,
	output logic o_ovf_flag_zero,
	output logic o_ovf_flag_one,
	output logic o_ext_irq_flag_zero,
	output logic o_ext_irq_flag_one
);

	////////////////////////////////////////////////////////////////////////
	// State.
	logic [7:0] timer_control_flags;
	logic [7:0] timer_mode_select;
	logic [7:0] count_low_byte [2];
	logic [7:0] count_high_byte [2];
	logic [3:0] presc;
	logic [1:0] cnt_smp;
	logic [1:0] irq_smp;
	logic [7:0] next_ctl;
	logic [7:0] next_mode;
	logic [7:0] next_lo [2];
	logic [7:0] next_hi [2];
	logic [3:0] next_presc;
	logic [1:0] next_cnt_smp;
	logic [1:0] next_irq_smp;
	logic [7:0] next_rdata;
	logic next_rate;
	logic tick;
	logic [1:0] fall;
	logic [1:0] irq_fall;
	logic [1:0] inc;
	logic [1:0] ovf;
	logic hi0_ovf;

	// Field extraction used for both timers.
	function automatic timer_pair_pkg::timer_mode_t mode_of(
		input logic [7:0] m, input int t);
		mode_of = timer_pair_pkg::timer_mode_t'(m[t*4 +: 2]);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Machine cycle strobe: one core clock in DIV, twelve by default.
	assign tick = (presc == 4'(DIV - 1));
	assign next_presc = tick ? 4'h0 : presc + 4'h1;

	// Edge detection works on samples taken at each machine cycle, so a
	// pulse shorter than one machine cycle may be missed entirely.
	assign fall[0] = cnt_smp[0] & ~i_count_input_zero;
	assign fall[1] = cnt_smp[1] & ~i_count_input_one;
	assign irq_fall[0] = irq_smp[0] & ~i_ext_irq_pin_zero;
	assign irq_fall[1] = irq_smp[1] & ~i_ext_irq_pin_one;
	assign next_cnt_smp = tick ? {i_count_input_one, i_count_input_zero}
		: cnt_smp;
	assign next_irq_smp = tick ? {i_ext_irq_pin_one, i_ext_irq_pin_zero}
		: irq_smp;

	////////////////////////////////////////////////////////////////////////
	// Increment enables for each timer.
	always_comb
	begin
		logic [1:0] run;
		logic [1:0] pin;
		run = {timer_control_flags[`TPC_RUN1_BIT],
			timer_control_flags[`TPC_RUN0_BIT]};
		pin = {i_ext_irq_pin_one, i_ext_irq_pin_zero};
		for (int t = 0; t < 2; t++)
		begin
			// Gate off, or gate on with pin high, plus the run bit.
			inc[t] = tick & run[t]
				& (~timer_mode_select[t*4 + `TPC_GATE_BIT] | pin[t])
				& (timer_mode_select[t*4 + `TPC_SEL_BIT] ?
				fall[t] : 1'b1);
		end
		// Timer one stands still in split mode.
		if (mode_of(timer_mode_select, 1) == timer_pair_pkg::MODE_SPLIT)
		begin
			inc[1] = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter next values per mode.
	always_comb
	begin
		hi0_ovf = 1'b0;
		for (int t = 0; t < 2; t++)
		begin
			next_lo[t] = count_low_byte[t];
			next_hi[t] = count_high_byte[t];
			ovf[t] = 1'b0;
			if (inc[t])
			begin
				case (mode_of(timer_mode_select, t))
					timer_pair_pkg::MODE_13BIT:
					begin
						// Upper three low-byte bits are left alone.
						next_lo[t][4:0] = count_low_byte[t][4:0] + 5'h01;
						if (count_low_byte[t][4:0] == 5'h1F)
						begin
							next_hi[t] = count_high_byte[t] + 8'h01;
							ovf[t] = (count_high_byte[t] == 8'hFF);
						end
					end
					timer_pair_pkg::MODE_16BIT:
					begin
						next_lo[t] = count_low_byte[t] + 8'h01;
						if (count_low_byte[t] == 8'hFF)
						begin
							next_hi[t] = count_high_byte[t] + 8'h01;
							ovf[t] = (count_high_byte[t] == 8'hFF);
						end
					end
					timer_pair_pkg::MODE_RELOAD8:
					begin
						next_lo[t] = count_low_byte[t] + 8'h01;
						if (count_low_byte[t] == 8'hFF)
						begin
							next_lo[t] = count_high_byte[t];
							ovf[t] = 1'b1;
						end
					end
					default:
					begin
						// Split: low byte is an 8-bit counter.
						next_lo[t] = count_low_byte[t] + 8'h01;
						ovf[t] = (count_low_byte[t] == 8'hFF);
					end
				endcase
			end
		end
		// Split: timer zero's high byte counts cycles on run one.
		if (mode_of(timer_mode_select, 0) == timer_pair_pkg::MODE_SPLIT
			&& tick && timer_control_flags[`TPC_RUN1_BIT])
		begin
			next_hi[0] = count_high_byte[0] + 8'h01;
			hi0_ovf = (count_high_byte[0] == 8'hFF);
		end
		// A software write to a count byte replaces this cycle's step.
		for (int t = 0; t < 2; t++)
		begin
			if (i_wr && i_addr == 8'(`TPC_CNT_LO0_ADDR + t))
				next_lo[t] = i_wdata;
			if (i_wr && i_addr == 8'(`TPC_CNT_HI0_ADDR + t))
				next_hi[t] = i_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control and mode writes; hardware sets win over clears.
	always_comb
	begin
		logic [7:0] c;
		c = timer_control_flags;
		next_mode = timer_mode_select;
		if (i_wr && i_addr == `TPC_CTL_ADDR)
		begin
			c = i_wdata;
		end
		else if (i_wr && i_addr == `TPC_MODE_ADDR)
		begin
			next_mode = i_wdata;
		end
		// Service acknowledges clear the flags.
		if (i_ack_ovf_zero)
		begin
			c[`TPC_OVF0_BIT] = 1'b0;
		end
		if (i_ack_ovf_one)
		begin
			c[`TPC_OVF1_BIT] = 1'b0;
		end
		// Level-triggered flags are left for software to clear.
		if (i_ack_irq_zero && c[`TPC_KIND0_BIT])
		begin
			c[`TPC_IRQF0_BIT] = 1'b0;
		end
		if (i_ack_irq_one && c[`TPC_KIND1_BIT])
		begin
			c[`TPC_IRQF1_BIT] = 1'b0;
		end
		// Overflow sets, after every clear so that they win over any clear.
		if (ovf[0])
		begin
			c[`TPC_OVF0_BIT] = 1'b1;
		end
		if (ovf[1] || hi0_ovf)
		begin
			c[`TPC_OVF1_BIT] = 1'b1;
		end
		// Pin detection: low level or sampled falling edge.
		if (timer_control_flags[`TPC_KIND0_BIT] ?
			(tick & irq_fall[0]) : ~i_ext_irq_pin_zero)
		begin
			c[`TPC_IRQF0_BIT] = 1'b1;
		end
		if (timer_control_flags[`TPC_KIND1_BIT] ?
			(tick & irq_fall[1]) : ~i_ext_irq_pin_one)
		begin
			c[`TPC_IRQF1_BIT] = 1'b1;
		end
		next_ctl = c;
		next_rate = ovf[1];
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, with unmapped addresses reading zero.
	always_comb
	begin
		next_rdata = 8'h00;
		if (i_rd && i_addr == `TPC_CTL_ADDR)
		begin
			next_rdata = timer_control_flags;
		end
		else if (i_rd && i_addr == `TPC_MODE_ADDR)
		begin
			next_rdata = timer_mode_select;
		end
		for (int t = 0; t < 2; t++)
		begin
			if (i_rd && i_addr == 8'(`TPC_CNT_LO0_ADDR + t))
				next_rdata = count_low_byte[t];
			if (i_rd && i_addr == 8'(`TPC_CNT_HI0_ADDR + t))
				next_rdata = count_high_byte[t];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers.
	always_ff @(posedge i_core_clk)
	begin
		if (!i_resetn)
		begin
			timer_control_flags <= `TPC_CTL_RST;
			timer_mode_select <= `TPC_MODE_RST;
			for (int t = 0; t < 2; t++)
			begin
				count_low_byte[t] <= `TPC_CNT_RST;
				count_high_byte[t] <= `TPC_CNT_RST;
			end
			presc <= 4'h0;
			cnt_smp <= 2'b00;
			irq_smp <= 2'b11;
			o_rdata <= 8'h00;
			o_rate_one <= 1'b0;
		end
		else
		begin
			timer_control_flags <= next_ctl;
			timer_mode_select <= next_mode;
			for (int t = 0; t < 2; t++)
			begin
				count_low_byte[t] <= next_lo[t];
				count_high_byte[t] <= next_hi[t];
			end
			presc <= next_presc;
			cnt_smp <= next_cnt_smp;
			irq_smp <= next_irq_smp;
			o_rdata <= next_rdata;
			o_rate_one <= next_rate;
		end
	end

	// Flag copies are taken from the register bits themselves.
	assign o_ovf_flag_zero = timer_control_flags[`TPC_OVF0_BIT];
	assign o_ovf_flag_one = timer_control_flags[`TPC_OVF1_BIT];
	assign o_ext_irq_flag_zero = timer_control_flags[`TPC_IRQF0_BIT];
	assign o_ext_irq_flag_one = timer_control_flags[`TPC_IRQF1_BIT];

	////////////////////////////////////////////////////////////////////////
	// Checks.
	sequence s_fall_zero;
		tick && i_count_input_zero ##DIV tick && !i_count_input_zero;
	endsequence

	// Cycles since the last strobe, counted apart from the prescaler.
	int tick_gap;
	always_ff @(posedge i_core_clk)
		tick_gap <= (!i_resetn || tick) ? 0 : tick_gap + 1;
	a_tick_period: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		tick == (tick_gap == DIV - 1)) else $error("bad cycle length");
	a_stop_split: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		timer_mode_select[5:4] == 2'b11
		&& !(i_wr && i_addr == `TPC_CNT_LO1_ADDR)
		|=> $stable(count_low_byte[1])) else $error("timer one moved");
	a_run_off: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		!timer_control_flags[`TPC_RUN0_BIT] && !i_wr
		|=> $stable(count_low_byte[0])) else $error("stopped timer moved");
	a_gate_hold: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		timer_mode_select[3] && !i_ext_irq_pin_zero && !i_wr
		&& timer_mode_select[1:0] != 2'b11
		|=> $stable(count_low_byte[0])) else $error("gated timer moved");
	a_reload: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		inc[0] && timer_mode_select[1:0] == 2'b10 && count_low_byte[0] == 8'hFF
		&& !i_wr |=> count_low_byte[0] == $past(count_high_byte[0])
		&& timer_control_flags[`TPC_OVF0_BIT]) else $error("no reload");
	a_ovf_set: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		ovf[0] |=> timer_control_flags[`TPC_OVF0_BIT]
		&& count_low_byte[0] != 8'hFF) else $error("overflow lost");
	a_edge_count: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		s_fall_zero ##0 (timer_mode_select[3:0] == 4'h5
		&& timer_control_flags[`TPC_RUN0_BIT] && !i_wr)
		|=> count_low_byte[0] == $past(count_low_byte[0]) + 8'h01)
		else $error("edge not counted");
	a_level_irq: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		!timer_control_flags[`TPC_KIND0_BIT] && !i_ext_irq_pin_zero && !i_wr
		|=> timer_control_flags[`TPC_IRQF0_BIT]) else $error("level missed");
	a_ack_clear: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
		i_ack_ovf_one && !ovf[1] && !hi0_ovf && !i_wr
		|=> !timer_control_flags[`TPC_OVF1_BIT]) else $error("ack ignored");

endmodule // timer_pair

// File: tb/count_pin_source.sv
// Model of the far side: the count pins and the interrupt/gate pins.
// Assumes the bench calls its tasks; pins idle high as with a pull-up.
`timescale 1ns/1ns

module count_pin_source #(
	parameter int HOLD = 8
)
(
	// Clock.
	input wire logic i_core_clk,
	// Pins: count zero, count one, interrupt zero, interrupt one.
	output logic [3:0] o_pins
);

logic [3:0] pins = 4'hF;

// Released pins rest high, which the pull-up would give.
assign o_pins = pins;

// Drives one pin to a level just after an edge and holds it there.
task set_pin(input int i, input logic v);
	@(posedge i_core_clk);
	pins[i] <= v;
	@(posedge i_core_clk);
endtask

// Each level is held two machine cycles so that both get sampled.
task fall(input int i);
	set_pin(i, 1'b0);
	repeat (HOLD) @(posedge i_core_clk);
	set_pin(i, 1'b1);
	repeat (HOLD) @(posedge i_core_clk);
endtask

endmodule // count_pin_source

// File: tb/timer_pair_tb.sv
// Self-checking bench for the dual timer/counter block.
// Assumes the pin source model drives the count and interrupt pins.
`include "timer_pair_consts.svh"
`timescale 1ns/1ns

module timer_pair_tb;

// A short machine cycle keeps the run brief; every flag wait and pin hold scales with it.
localparam int DIV = 4;
localparam int TICK = DIV + 3;
logic i_core_clk = 1'b0;
logic i_resetn = 1'b0;
logic [7:0] i_addr = 8'h00;
logic [7:0] i_wdata = 8'h00;
logic i_wr = 1'b0;
logic i_rd = 1'b0;
logic [3:0] ack = 4'h0;
logic [7:0] o_rdata;
logic o_rate_one;
logic seen;
wire [3:0] pin;
wire [3:0] flag;
int miscompares = 0;
int n_checks = 0;
int cycles = 0;
int rates = 0;

always #4 i_core_clk = ~i_core_clk;

timer_pair #(.DIV(DIV)) uut (
	.i_core_clk(i_core_clk), .i_resetn(i_resetn),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata),
	.i_count_input_zero(pin[0]), .i_count_input_one(pin[1]),
	.i_ext_irq_pin_zero(pin[2]), .i_ext_irq_pin_one(pin[3]),
	.i_ack_ovf_zero(ack[0]), .i_ack_ovf_one(ack[1]),
	.i_ack_irq_zero(ack[2]), .i_ack_irq_one(ack[3]),
	.o_rate_one(o_rate_one),
	.o_ovf_flag_zero(flag[0]), .o_ovf_flag_one(flag[1]),
	.o_ext_irq_flag_zero(flag[2]), .o_ext_irq_flag_one(flag[3])
);

count_pin_source #(.HOLD(2 * DIV)) src (
	.i_core_clk(i_core_clk),
	.o_pins(pin)
);

////////////////////////////////////////////////////////////////////////
// The ceiling cuts a hang short; rate pulses are counted on the side.
always @(posedge i_core_clk)
begin
	cycles <= cycles + 1;
	if (o_rate_one === 1'b1)
		rates <= rates + 1;
	if (cycles == 8000)
	begin
		miscompares = miscompares + 1;
		final_report();
	end
end

task final_report;
	$display("checks %0d mismatches %0d", n_checks, miscompares);
	if (miscompares == 0 && n_checks > 0)
		$display("ALL TESTS PASSED");
	else
		$display("TESTS FAILED");
	$finish;
endtask

task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
	n_checks++;
	if (got !== exp)
	begin
		$display("Error %s expected %h seen %h", what, exp, got);
		miscompares++;
	end
endtask

task chkb(input string what, input logic exp, input logic got);
	chk(what, {7'h00, exp}, {7'h00, got});
endtask

task wr(input logic [7:0] a, input logic [7:0] d);
	@(posedge i_core_clk);
	i_wr <= 1'b1;
	i_addr <= a;
	i_wdata <= d;
	@(posedge i_core_clk);
	i_wr <= 1'b0;
endtask

// Read data stand only in the cycle after the strobe, so look there.
task rd(input logic [7:0] a, input logic [7:0] exp);
	@(posedge i_core_clk);
	i_rd <= 1'b1;
	i_addr <= a;
	@(posedge i_core_clk);
	i_rd <= 1'b0;
	#1;
	chk($sformatf("register %h", a), exp, o_rdata);
endtask

task wait_flag(input int w, input int lim);
	seen = 1'b0;
	for (int k = 0; k < lim && !seen; k++)
	begin
		@(posedge i_core_clk);
		#1;
		if (flag[w] === 1'b1)
			seen = 1'b1;
	end
endtask

task pulse_ack(input int w);
	@(posedge i_core_clk);
	ack[w] <= 1'b1;
	@(posedge i_core_clk);
	ack[w] <= 1'b0;
	#1;
endtask

// Stops first, so a preload is never split by a running tick.
task setup(input int t, input logic [7:0] mode, lo, hi, ctl);
	wr(`TPC_CTL_ADDR, 8'h00);
	wr(`TPC_MODE_ADDR, mode);
	wr(8'(`TPC_CNT_LO0_ADDR + t), lo);
	wr(8'(`TPC_CNT_HI0_ADDR + t), hi);
	wr(`TPC_CTL_ADDR, ctl);
endtask

task run_ovf(input int t, input logic [7:0] mode, lo, hi, exp_hi);
	setup(t, mode, lo, hi, t ? 8'h40 : 8'h10);
	wait_flag(t, TICK);
	chkb("overflow flag", 1'b1, seen);
	pulse_ack(t);
	chkb("serviced flag", 1'b0, flag[t]);
	wr(`TPC_CTL_ADDR, 8'h00);
	rd(8'(`TPC_CNT_HI0_ADDR + t), exp_hi);
endtask

////////////////////////////////////////////////////////////////////////
// Main sequence.
initial
begin
	int r0;
	repeat (4) @(posedge i_core_clk);
	i_resetn <= 1'b1;
	rd(`TPC_CTL_ADDR, `TPC_CTL_RST);
	rd(`TPC_MODE_ADDR, `TPC_MODE_RST);
	rd(`TPC_CNT_HI1_ADDR, `TPC_CNT_RST);
	rd(8'hFF, 8'h00);
	wr(`TPC_MODE_ADDR, 8'hA5);
	rd(`TPC_MODE_ADDR, 8'hA5);
	$display("test registers done");
	run_ovf(0, 8'h00, 8'h1F, 8'hFF, 8'h00);
	run_ovf(0, 8'h01, 8'hFF, 8'hFF, 8'h00);
	run_ovf(0, 8'h02, 8'hFF, 8'h5A, 8'h5A);
	r0 = rates;
	run_ovf(1, 8'h10, 8'hFF, 8'hFF, 8'h00);
	chk("rate pulses", 8'h01, 8'(rates - r0));
	$display("test modes done");
	src.set_pin(2, 1'b0);
	setup(0, 8'h09, 8'hFF, 8'hFF, 8'h10);
	wait_flag(0, 3 * DIV);
	chkb("gated overflow", 1'b0, seen);
	src.set_pin(2, 1'b1);
	wait_flag(0, TICK);
	chkb("open gate overflow", 1'b1, seen);
	setup(0, 8'h05, 8'hFF, 8'hFF, 8'h10);
	wait_flag(0, 3 * DIV);
	chkb("idle count pin", 1'b0, seen);
	src.fall(0);
	wait_flag(0, TICK);
	chkb("counted edge", 1'b1, seen);
	setup(1, 8'h30, 8'hFF, 8'hFF, 8'h40);
	wait_flag(1, 3 * DIV);
	chkb("held timer one", 1'b0, seen);
	setup(0, 8'h33, 8'h00, 8'hFF, 8'h40);
	wait_flag(1, TICK);
	chkb("split high byte", 1'b1, seen);
	$display("test counting done");
	wr(`TPC_CTL_ADDR, 8'h05);
	src.fall(2);
	wait_flag(2, TICK);
	chkb("edge interrupt", 1'b1, seen);
	rd(`TPC_CTL_ADDR, 8'h07);
	pulse_ack(2);
	chkb("edge serviced", 1'b0, flag[2]);
	wr(`TPC_CTL_ADDR, 8'h00);
	src.set_pin(3, 1'b0);
	wait_flag(3, TICK);
	chkb("level interrupt", 1'b1, seen);
	// Release the pin first, or its low level would hide a wrong clear.
	src.set_pin(3, 1'b1);
	pulse_ack(3);
	chkb("level kept", 1'b1, flag[3]);
	wr(`TPC_CTL_ADDR, 8'h00);
	rd(`TPC_CTL_ADDR, 8'h00);
	$display("test interrupts done");
	final_report();
end

endmodule // timer_pair_tb
